// File: src/ubi_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 4-bit word address on the register port
`ifndef UBI_REGS_SVH
`define UBI_REGS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define UBI_OFF_STATUS 4'h0
`define UBI_OFF_ENABLE 4'h1
`define UBI_OFF_IDENT 4'h2
`define UBI_OFF_CMD 4'h3
`define UBI_OFF_TIMER_STATUS_REG 4'h4
`define UBI_OFF_TMEN 4'h5
`define UBI_OFF_LINE 4'h6
`define UBI_OFF_RXST 4'h7
`define UBI_OFF_RXEN 4'h8
`define UBI_OFF_MDST 4'h9
`define UBI_OFF_MDEN 4'hA
`define UBI_OFF_MODE 4'hB
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UBI_CMD_ACK 0
`define UBI_CMD_STC 1
`define UBI_CMD_SWRST 2
`define UBI_MODE_AUTO 0
`define UBI_LINE_TXFIFO 5
`define UBI_LINE_TXIDLE 6
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define UBI_RST_STATUS 8'h00
`define UBI_RST_ENABLE 8'h00
`define UBI_RST_BANK 2'h0
`define UBI_ACK_LOW_CYCLES 2'h2
`endif

// File: src/ubi_pkg.sv
// types shared by the interrupt logic
// assumes nothing beyond a SystemVerilog compiler
package ubi_pkg;
    // whole state of the interrupt logic
    typedef struct packed {
        logic [1:0] tmStat;  // timer sources
        logic [1:0] tmEn;    // timer source enables
        logic txIdle;        // transmit machine idle
        logic [7:1] rxStat;  // receive machine sources
        logic [7:1] rxEn;    // receive source enables
        logic rxFifo;        // receive fifo request
        logic txFifo;        // transmit fifo request
        logic [3:0] mdStat;  // modem sources
        logic [3:0] mdEn;    // modem source enables
        logic [5:0] block_request_enable;     // block request enables
        logic [1:0] bank;    // bank selector
        logic autoAck;       // automatic acknowledge mode
        logic [1:0] lowCnt;  // forced low window
        logic intOut;        // interrupt output
        logic [7:0] rdData;  // read data
    } ubi_state_s;
endpackage

// File: src/ubi_interrupt_logic.sv
// interrupt logic of a serial controller: sources, block requests,
// priority resolver, identification code and acknowledge modes
// assumes source events and service pulses come from same-clock logic
//
// Notes on behaviour
// - receive machine has seven sticky sources
// - block request set by any enabled source
// - status read clears block, not rx fifo
// - six block bits, interrupt needs block enable
// - block enable writable at any time
// - fixed priority codes timers 5 to modem 0
// - highest enabled request encoded in bits 3..1
// - code tracks requests continuously, always readable
// - manual mode: acknowledge command drops output
// - auto mode: service forces two low cycles
// - auto mode: any enabled serviced block triggers acknowledge
// - early manual acknowledge re-raises the interrupt
// - request stays until its status bit clears
// - source or block mask removes the request
// - status clear resets every source
// - timer bits, serviced by read or clear
// - tx idle serviced by character write or clear
// - rx sources serviced by read or zero write
// - rx fifo serviced by zero write or read
// - tx fifo serviced by write or ident read
// - modem sources serviced by read or zero write
// - manual mode: service never drops output
// - enabled request raises output and shows code
// - lower request re-edges only after acknowledge
// - software reset masks all and selects bank zero
`timescale 1ns/1ps
`include "ubi_regs.svh"
module ubi_interrupt_logic
    import ubi_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic [1:0] tmrEvent,
    input wire logic txIdleEvent,
    input wire logic [7:1] rxEvent,
    input wire logic rxFifoEvent,
    input wire logic txFifoEvent,
    input wire logic [3:0] modemEvent,
    input wire logic txCharWrite,
    input wire logic rxCharRead,
    output logic intReq
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // defaults after hardware or software reset
    function automatic ubi_state_s ubi_reset();
        ubi_state_s r;
        r = '0;
        r.tmStat = 2'(`UBI_RST_STATUS);
        r.rxStat = 7'(`UBI_RST_STATUS);
        r.mdStat = 4'(`UBI_RST_STATUS);
        r.tmEn = 2'(`UBI_RST_ENABLE);
        r.rxEn = 7'(`UBI_RST_ENABLE);
        r.mdEn = 4'(`UBI_RST_ENABLE);
        r.block_request_enable = 6'(`UBI_RST_ENABLE);
        r.bank = `UBI_RST_BANK;
        return r;
    endfunction

    // block request bits from enabled source bits
    function automatic logic [5:0] ubi_blk(input ubi_state_s x);
        logic [5:0] b;
        b[5] = |(x.tmStat & x.tmEn);
        b[4] = x.txIdle;
        b[3] = |(x.mdStat & x.mdEn);
        b[2] = |(x.rxStat & x.rxEn);
        b[1] = x.txFifo;
        b[0] = x.rxFifo;
        return b;
    endfunction

    // fixed priority resolver, timers highest
    function automatic logic [2:0] ubi_prio(input logic [5:0] p);
        logic [2:0] c;
        c = 3'h0;
        // block bits: 5 timers, 4 tx machine, 3 modem, 2 rx machine, 1 tx fifo, 0 rx fifo
        if (p[5]) begin
            c = 3'h5;
        end else if (p[4]) begin
            c = 3'h4;
        end else if (p[2]) begin
            c = 3'h3;
        end else if (p[0]) begin
            c = 3'h2;
        end else if (p[1]) begin
            c = 3'h1;
        end
        return c;
    endfunction

    // ----------------------------------------------------------------
    // state and decode
    // ----------------------------------------------------------------
    ubi_state_s s;  // registered state
    ubi_state_s next_s;  // next state
    logic [5:0] blkStat;  // block request bits
    logic [5:0] enPend;  // enabled block requests
    logic [2:0] code;  // identification code
    logic rdT;  // timer status read
    logic rdL;  // line status read
    logic rdR;  // receive status read
    logic rdM;  // modem status read
    logic rdI;  // identification read
    logic wrL;  // line status write
    logic wrR;  // receive status write
    logic wrM;  // modem status write
    logic status_clear_command;  // status clear command
    logic ackCmd;  // manual acknowledge command
    logic swRst;  // software reset command
    logic [1:0] tmClr;  // timer clear mask
    logic [7:1] rxClr;  // receive clear mask
    logic [3:0] mdClr;  // modem clear mask
    logic rxFifoClr;  // receive fifo clear
    logic txFifoClr;  // transmit fifo clear
    logic txIdleClr;  // transmit idle clear
    logic svc;  // a service operation happens
    logic trig;  // acknowledge starts the low window

    assign blkStat = ubi_blk(s);
    assign enPend = blkStat & s.block_request_enable;
    assign code = ubi_prio(enPend);

    // read and write strobes per register
    assign rdT = regRdStb && regAddr == `UBI_OFF_TIMER_STATUS_REG;
    assign rdL = regRdStb && regAddr == `UBI_OFF_LINE;
    assign rdR = regRdStb && regAddr == `UBI_OFF_RXST;
    assign rdM = regRdStb && regAddr == `UBI_OFF_MDST;
    assign rdI = regRdStb && regAddr == `UBI_OFF_IDENT;
    assign wrL = regWrStb && regAddr == `UBI_OFF_LINE;
    assign wrR = regWrStb && regAddr == `UBI_OFF_RXST;
    assign wrM = regWrStb && regAddr == `UBI_OFF_MDST;

    // command register bits
    assign status_clear_command = regWrStb && regAddr == `UBI_OFF_CMD && regWrData[`UBI_CMD_STC];
    assign ackCmd = regWrStb && regAddr == `UBI_OFF_CMD && regWrData[`UBI_CMD_ACK];
    assign swRst = regWrStb && regAddr == `UBI_OFF_CMD && regWrData[`UBI_CMD_SWRST];

    // ----------------------------------------------------------------
    // service clear masks
    // ----------------------------------------------------------------
    // timers: read of timer status or status clear
    assign tmClr = {2{status_clear_command || rdT}};
    // receive: read clears all, zero write clears the bit
    assign rxClr = {7{status_clear_command || rdL || rdR}}
        | (wrR ? ~regWrData[7:1] : 7'h00)
        | (wrL ? {3'h0, ~regWrData[4:1]} : 7'h00);
    // modem: read clears all, zero write clears the bit
    assign mdClr = {4{status_clear_command || rdM}} | (wrM ? ~regWrData[3:0] : 4'h0);
    // rx fifo survives status reads
    assign rxFifoClr = status_clear_command || rxCharRead || ((wrL || wrR) && !regWrData[0]);
    assign txFifoClr = status_clear_command || txCharWrite || rdI;
    assign txIdleClr = status_clear_command || txCharWrite;
    // any operation that may service a source
    assign svc = status_clear_command || rdT || rdL || rdR || rdM || rdI || wrL || wrR || wrM
        || txCharWrite || rxCharRead;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        trig = 1'b0;
        // sticky sources, a set in the clear cycle wins
        next_s.tmStat = (s.tmStat & ~tmClr) | tmrEvent;
        next_s.rxStat = (s.rxStat & ~rxClr) | rxEvent;
        next_s.mdStat = (s.mdStat & ~mdClr) | modemEvent;
        next_s.rxFifo = (s.rxFifo & ~rxFifoClr) | rxFifoEvent;
        next_s.txFifo = (s.txFifo & ~txFifoClr) | txFifoEvent;
        next_s.txIdle = (s.txIdle & ~txIdleClr) | txIdleEvent;
        // configuration writes
        if (regWrStb) begin
            case (regAddr)
                `UBI_OFF_ENABLE: begin
                    next_s.block_request_enable = regWrData[5:0];
                end
                `UBI_OFF_TMEN: begin
                    next_s.tmEn = regWrData[1:0];
                end
                `UBI_OFF_RXEN: begin
                    next_s.rxEn = regWrData[7:1];
                end
                `UBI_OFF_MDEN: begin
                    next_s.mdEn = regWrData[3:0];
                end
                `UBI_OFF_MODE: begin
                    next_s.autoAck = regWrData[`UBI_MODE_AUTO];
                end
                `UBI_OFF_IDENT: begin
                    next_s.bank = regWrData[6:5];
                end
                default: begin
                    // other offsets hold no configuration
                end
            endcase
        end
        // read data, valid only in the cycle after the strobe
        next_s.rdData = 8'h00;
        if (regRdStb) begin
            case (regAddr)
                `UBI_OFF_STATUS: next_s.rdData = {2'h0, blkStat};
                `UBI_OFF_ENABLE: next_s.rdData = {2'h0, s.block_request_enable};
                `UBI_OFF_IDENT: begin
                    // bit 0 high when nothing is pending
                    next_s.rdData = {1'b0, s.bank, 1'b0, code, ~(|enPend)};
                end
                `UBI_OFF_TIMER_STATUS_REG: next_s.rdData = {6'h00, s.tmStat};
                `UBI_OFF_TMEN: next_s.rdData = {6'h00, s.tmEn};
                `UBI_OFF_LINE: begin
                    next_s.rdData = {1'b0, s.txIdle, s.txFifo, s.rxStat[4:1], s.rxFifo};
                end
                `UBI_OFF_RXST: next_s.rdData = {s.rxStat, s.rxFifo};
                `UBI_OFF_RXEN: next_s.rdData = {s.rxEn, 1'b0};
                `UBI_OFF_MDST: next_s.rdData = {4'h0, s.mdStat};
                `UBI_OFF_MDEN: next_s.rdData = {4'h0, s.mdEn};
                `UBI_OFF_MODE: next_s.rdData = {7'h00, s.autoAck};
                default: next_s.rdData = 8'h00;  // unmapped reads zero
            endcase
        end
        // acknowledge decision
        if (s.autoAck) begin
            // an enabled request that a service drops
            trig = svc && |(enPend & ~(ubi_blk(next_s) & next_s.block_request_enable));
        end else begin
            trig = ackCmd;
        end
        // interrupt output
        if (trig) begin
            next_s.lowCnt = `UBI_ACK_LOW_CYCLES - 2'h1;
            next_s.intOut = 1'b0;
        end else if (s.lowCnt != 2'h0) begin
            // still inside the forced low window
            next_s.lowCnt = s.lowCnt - 2'h1;
            next_s.intOut = 1'b0;
        end else if (!s.autoAck && s.intOut) begin
            // manual mode holds until acknowledged
            next_s.intOut = 1'b1;
        end else begin
            // raise on any enabled request
            next_s.intOut = |enPend;
        end
        // software reset returns everything to defaults
        if (swRst) begin
            next_s = ubi_reset();
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s <= ubi_reset();
        end else begin
            s <= next_s;
        end
    end

    assign regRdData = s.rdData;
    assign intReq = s.intOut;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic anyEvt;  // any source event this cycle
    assign anyEvt = |{tmrEvent, txIdleEvent, rxEvent, rxFifoEvent, txFifoEvent, modemEvent};

    AST_BLOCK_READ: assert property (@(posedge clock) disable iff (sys_rst)
        regRdStb && regAddr == `UBI_OFF_STATUS |=> regRdData == {2'h0, $past(blkStat)})
        else $error("block status read does not show the block bits");

    AST_RX_READ_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
        rdR && !swRst && !(|rxEvent) && !rxFifoEvent && !rxCharRead
        |=> s.rxStat == 7'h00 && s.rxFifo == $past(s.rxFifo))
        else $error("receive status read cleared wrongly");

    AST_TOP_CODE: assert property (@(posedge clock) disable iff (sys_rst)
        enPend[5] |-> code == 3'h5)
        else $error("timer request not encoded as highest");

    AST_LOW_CODE: assert property (@(posedge clock) disable iff (sys_rst)
        enPend == 6'h08 |-> code == 3'h0)
        else $error("lowest request code wrong");

    AST_AUTO_LOW: assert property (@(posedge clock) disable iff (sys_rst)
        s.autoAck && trig && !swRst |=> !intReq ##1 !intReq)
        else $error("acknowledge low window shorter than two cycles");

    AST_AUTO_REEVAL: assert property (@(posedge clock) disable iff (sys_rst)
        s.autoAck && trig && !swRst ##1 !trig ##1 (|enPend && !trig && !swRst) |=> intReq)
        else $error("output not raised again after the low window");

    AST_MASK_DROP: assert property (@(posedge clock) disable iff (sys_rst)
        s.autoAck && enPend == 6'h00 && s.lowCnt == 2'h0 |=> !intReq)
        else $error("masked requests still drive the output");

    AST_MANUAL_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
        !s.autoAck && intReq && !ackCmd && !swRst |=> intReq)
        else $error("manual mode output fell without acknowledge");

    AST_MANUAL_REARM: assert property (@(posedge clock) disable iff (sys_rst)
        !s.autoAck && ackCmd && !swRst ##1 !ackCmd
        ##1 (|enPend && !ackCmd && !swRst && !s.autoAck) |=> intReq)
        else $error("early acknowledge did not re-raise the output");

    AST_STATUS_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
        status_clear_command && !anyEvt |=> blkStat == 6'h00)
        else $error("status clear left a source active");

    AST_SW_RESET: assert property (@(posedge clock) disable iff (sys_rst)
        swRst |=> s.block_request_enable == 6'h00 && s.bank == 2'h0 && !intReq)
        else $error("software reset left blocks enabled");

    // ----------------------------------------------------------------
    // resolver and per-source service checks
    // ----------------------------------------------------------------
    // receive fifo alone sits above transmit fifo and modem
    AST_RXFIFO_CODE: assert property (@(posedge clock) disable iff (sys_rst)
        enPend == 6'h01 |-> code == 3'h2)
        else $error("receive fifo request not encoded as code two");

    // receive machine outranks both fifos and the modem block
    AST_RXM_CODE: assert property (@(posedge clock) disable iff (sys_rst)
        enPend[2] && !enPend[5] && !enPend[4] |-> code == 3'h3)
        else $error("receive machine request not encoded as code three");

    // manual acknowledge opens the two-cycle low window
    AST_MANUAL_ACK: assert property (@(posedge clock) disable iff (sys_rst)
        !s.autoAck && ackCmd && !swRst |=> !intReq ##1 !intReq)
        else $error("manual acknowledge did not drop the output");

    // an enabled request raises the output outside the low window
    AST_MANUAL_RAISE: assert property (@(posedge clock) disable iff (sys_rst)
        !s.autoAck && s.lowCnt == 2'h0 && |enPend && !ackCmd && !swRst
        |=> intReq)
        else $error("enabled request did not raise the output");

    // a pending timer bit stays until something services it
    AST_SOURCE_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
        s.tmStat[0] && !status_clear_command && !rdT && !swRst |=> s.tmStat[0])
        else $error("timer source dropped without service");

    // timer status read clears both timer sources
    AST_TIMER_READ: assert property (@(posedge clock) disable iff (sys_rst)
        rdT && !(|tmrEvent) |=> s.tmStat == 2'h0)
        else $error("timer status read left a source active");

    // a character write services transmit idle
    AST_TXIDLE_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
        txCharWrite && !txIdleEvent |=> !s.txIdle)
        else $error("character write did not clear transmit idle");

    // an identification read services the transmit fifo request
    AST_TXFIFO_IDENT: assert property (@(posedge clock) disable iff (sys_rst)
        rdI && !txFifoEvent |=> !s.txFifo)
        else $error("identification read did not clear transmit fifo request");

    // modem status read clears every modem source
    AST_MODEM_READ: assert property (@(posedge clock) disable iff (sys_rst)
        rdM && !(|modemEvent) |=> s.mdStat == 4'h0)
        else $error("modem status read left a source active");

endmodule

// File: dv/ubi_host_model.sv
// host side model: an edge-triggered interrupt controller input
// assumes the device interrupt output is registered on the same clock
`timescale 1ns/1ps
module ubi_host_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic intReq,
    output logic [7:0] edgeCount
);
    logic lastReq; // previous sample of the request line
    // ----------------------------------------------------------------
    // edge capture
    // ----------------------------------------------------------------
    // one request latched per rising edge; a level held high is not
    // seen again, so the device must drop and re-raise the line
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lastReq <= 1'b0;
            edgeCount <= 8'h00;
        end else begin
            lastReq <= intReq;
            if (intReq && !lastReq) begin
                edgeCount <= edgeCount + 8'h01;
            end
        end
    end
endmodule

// File: dv/ubi_interrupt_logic_tb_top.sv
// self-checking bench for the interrupt logic
// assumes the register map and timing of ubi_regs.svh
`timescale 1ns/1ps
`include "ubi_regs.svh"
module ubi_interrupt_logic_tb_top;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clock, sysRst, regWrStb, regRdStb, txIdleEvent, rxFifoEvent;
    logic txFifoEvent, txCharWrite, rxCharRead, intReq, rdLast;
    logic [3:0] regAddr, modemEvent;
    logic [7:0] regWrData, regRdData, edgeCount, e0;
    logic [1:0] tmrEvent;
    logic [7:1] rxEvent;
    logic [5:0] m, g, en;
    logic [7:0] expQ[$]; // expected read data, oldest first
    int nFail, numChecks;
    ubi_interrupt_logic dut (.clock(clock), .sys_rst(sysRst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .tmrEvent(tmrEvent), .txIdleEvent(txIdleEvent),
        .rxEvent(rxEvent), .rxFifoEvent(rxFifoEvent), .txFifoEvent(txFifoEvent),
        .modemEvent(modemEvent), .txCharWrite(txCharWrite), .rxCharRead(rxCharRead),
        .intReq(intReq));
    ubi_host_model host (.clock(clock), .sys_rst(sysRst), .intReq(intReq),
        .edgeCount(edgeCount));
    // free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic compare(input string nm, input logic [7:0] e, input logic [7:0] s);
        numChecks++;
        if (s !== e) begin
            nFail++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic printVerdict();
        $display("checks %0d errors %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic at(input int n);
        repeat (n) @(posedge clock);
    endtask
    // interrupt level, looked at just after an edge has landed
    task automatic lvl(input logic e);
        #1 compare("intReq", {7'h00, e}, {7'h00, intReq});
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clock);
        regWrStb <= 1'b0;
    endtask
    // read: the expectation is queued, the monitor compares it
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        regAddr <= a;
        regRdStb <= 1'b1;
        expQ.push_back(e);
        @(posedge clock);
        regRdStb <= 1'b0;
    endtask
    // one-cycle source events, mask ordered by priority code
    task automatic pulse(input logic [5:0] c, input logic [7:1] rv);
        @(posedge clock);
        tmrEvent <= {1'b0, c[5]};
        txIdleEvent <= c[4];
        rxEvent <= c[3] ? rv : 7'h00;
        rxFifoEvent <= c[2];
        txFifoEvent <= c[1];
        modemEvent <= {3'h0, c[0]};
        @(posedge clock);
        {tmrEvent, txIdleEvent, rxEvent, rxFifoEvent, txFifoEvent, modemEvent} <= '0;
    endtask
    task automatic strobe(input logic isTx);
        @(posedge clock);
        txCharWrite <= isTx;
        rxCharRead <= !isTx;
        @(posedge clock);
        txCharWrite <= 1'b0;
        rxCharRead <= 1'b0;
    endtask
    // priority-code order to block status bit order
    function automatic logic [5:0] toStat(input logic [5:0] c);
        return {c[5], c[4], c[0], c[3], c[1], c[2]};
    endfunction
    // identification: code of highest enabled request, bit0 when idle
    function automatic logic [7:0] identOf(input logic [5:0] c);
        logic [2:0] hi;
        hi = 3'h0;
        for (int k = 0; k < 6; k++) begin
            if (c[k]) begin
                hi = 3'(k);
            end
        end
        return {4'h0, hi, ~|c};
    endfunction
    // ----------------------------------------------------------------
    // read monitor
    // ----------------------------------------------------------------
    always @(posedge clock) rdLast <= regRdStb;
    always @(negedge clock) begin
        if (rdLast && expQ.size() > 0) begin
            compare("regRdData", expQ.pop_front(), regRdData);
        end
    end
    // watchdog: far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        nFail++;
        printVerdict();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {regWrStb, regRdStb, txIdleEvent, rxFifoEvent, txFifoEvent} = '0;
        {txCharWrite, rxCharRead, tmrEvent, rxEvent, modemEvent} = '0;
        regAddr = 4'h0;
        regWrData = 8'h00;
        sysRst = 1'b1;
        at(12);
        sysRst <= 1'b0;
        void'($urandom(48171));
        rd(`UBI_OFF_STATUS, 8'h00);
        rd(`UBI_OFF_ENABLE, 8'h00);
        rd(`UBI_OFF_IDENT, 8'h01);
        wr(4'hC, 8'hFF);
        rd(4'hC, 8'h00);
        wr(`UBI_OFF_TMEN, 8'h03);
        wr(`UBI_OFF_RXEN, 8'hFE);
        wr(`UBI_OFF_MDEN, 8'h0F);
        // random requests and block masks, manual acknowledge
        for (int i = 0; i < 12; i++) begin
            m = 6'($urandom_range(63, 1));
            g = 6'($urandom());
            en = m & g;
            wr(`UBI_OFF_ENABLE, {2'h0, toStat(g)});
            pulse(m, 7'($urandom_range(127, 1)));
            at(1);
            lvl(|en);
            rd(`UBI_OFF_STATUS, {2'h0, toStat(m)});
            rd(`UBI_OFF_IDENT, identOf(en));
            rd(`UBI_OFF_STATUS, {2'h0, toStat(m & 6'h3D)});
            wr(`UBI_OFF_CMD, 8'h02);
            lvl(|en);
            rd(`UBI_OFF_STATUS, 8'h00);
            wr(`UBI_OFF_CMD, 8'h01);
            lvl(1'b0);
            at(2);
            lvl(1'b0);
        end
        // automatic acknowledge: timer and modem pending
        wr(`UBI_OFF_MODE, 8'h01);
        wr(`UBI_OFF_ENABLE, 8'h3F);
        pulse(6'h21, 7'h00);
        at(5);
        lvl(1'b1);
        rd(`UBI_OFF_IDENT, 8'h0A);
        rd(`UBI_OFF_MDST, 8'h01);
        lvl(1'b0);
        at(1);
        lvl(1'b0);
        at(1);
        lvl(1'b1);
        rd(`UBI_OFF_TIMER_STATUS_REG, 8'h01);
        lvl(1'b0);
        at(2);
        lvl(1'b0);
        // source and block masks
        pulse(6'h20, 7'h00);
        at(1);
        lvl(1'b1);
        wr(`UBI_OFF_TMEN, 8'h00);
        at(1);
        lvl(1'b0);
        rd(`UBI_OFF_STATUS, 8'h00);
        wr(`UBI_OFF_TMEN, 8'h03);
        wr(`UBI_OFF_ENABLE, 8'h1F);
        at(1);
        lvl(1'b0);
        rd(`UBI_OFF_STATUS, 8'h20);
        wr(`UBI_OFF_CMD, 8'h02);
        wr(`UBI_OFF_ENABLE, 8'h3F);
        // per-source service paths
        pulse(6'h0C, 7'h7F);
        rd(`UBI_OFF_RXST, 8'hFF);
        rd(`UBI_OFF_LINE, 8'h01);
        strobe(1'b0);
        rd(`UBI_OFF_LINE, 8'h00);
        pulse(6'h12, 7'h00);
        rd(`UBI_OFF_LINE, 8'h60);
        strobe(1'b1);
        rd(`UBI_OFF_LINE, 8'h00);
        pulse(6'h01, 7'h00);
        wr(`UBI_OFF_MDST, 8'h00);
        rd(`UBI_OFF_MDST, 8'h00);
        pulse(6'h08, 7'h02);
        wr(`UBI_OFF_LINE, 8'h00);
        rd(`UBI_OFF_RXST, 8'h00);
        // manual acknowledge before and after service
        wr(`UBI_OFF_MODE, 8'h00);
        pulse(6'h21, 7'h00);
        at(1);
        lvl(1'b1);
        e0 = edgeCount;
        wr(`UBI_OFF_CMD, 8'h01);
        at(3);
        lvl(1'b1);
        rd(`UBI_OFF_TIMER_STATUS_REG, 8'h01);
        wr(`UBI_OFF_CMD, 8'h01);
        at(3);
        lvl(1'b1);
        rd(`UBI_OFF_MDST, 8'h01);
        wr(`UBI_OFF_CMD, 8'h01);
        at(3);
        lvl(1'b0);
        // the first rise is counted by the host one edge after e0 is taken
        compare("edgeCount", e0 + 8'h03, edgeCount);
        // bank field and software reset
        wr(`UBI_OFF_IDENT, 8'h60);
        rd(`UBI_OFF_IDENT, 8'h61);
        pulse(6'h20, 7'h00);
        wr(`UBI_OFF_CMD, 8'h04);
        rd(`UBI_OFF_ENABLE, 8'h00);
        rd(`UBI_OFF_IDENT, 8'h01);
        rd(`UBI_OFF_STATUS, 8'h00);
        at(3);
        lvl(1'b0);
        printVerdict();
    end
endmodule
